//--- dv/test_test_timing_sequencer.sv
// self-checking bench for the test timing sequencer
module test_test_timing_sequencer;
	timeunit 1ns;
	timeprecision 1ps;

	// clock, reset and apb master signals
	logic                  clk;
	logic                  reset;
	logic                  psel;
	logic                  penable;
	logic                  pwrite;
	logic [7:0]            paddr;
	logic [31:0]           pwdata;
	logic [31:0]           prdata;
	logic [31:0]           rd;
	logic                  pready;
	logic                  pslverr;
	logic                  err;
	// panel pins and outputs
	logic                  start_key;
	logic                  stop_key;
	logic                  overload_in;
	logic                  sec_tick_in;
	logic                  lamp_on;
	logic                  lamp_flash;
	logic                  beep;
	logic                  load_en;
	logic                  irq;
	tts_pkg::tts_meas_type meas;
	int                    error_cnt = 0;
	int                    n_compared = 0;
	int                    clr_cnt = 0;
	int                    c;

	always #2.5 clk = ~clk;

	tts_top dut (
		.clk        (clk),
		.reset      (reset),
		.psel       (psel),
		.penable    (penable),
		.pwrite     (pwrite),
		.paddr      (paddr),
		.pwdata     (pwdata),
		.prdata     (prdata),
		.pready     (pready),
		.pslverr    (pslverr),
		.start_key  (start_key),
		.stop_key   (stop_key),
		.overload_in(overload_in),
		.sec_tick_in(sec_tick_in),
		.lamp_on    (lamp_on),
		.lamp_flash (lamp_flash),
		.beep       (beep),
		.load_en    (load_en),
		.meas       (meas),
		.irq        (irq)
	);

	tts_panel panel (
		.clk        (clk),
		.start_key  (start_key),
		.stop_key   (stop_key),
		.overload_in(overload_in),
		.sec_tick_in(sec_tick_in)
	);

	// count one-cycle clear pulses; a missed pulse shows up as a short count
	always @(posedge clk) begin
		if (meas.minmax_clr === 1'b1)
			clr_cnt <= clr_cnt + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	// one apb transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		// no wait-state count assumed; only the watchdog ends a stuck wait
		do begin
			@(posedge clk);
		end while (pready !== 1'b1);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(negedge clk);
	endtask : apb

	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h00000000);
		chk(rd & m, e);
	endtask : rdchk

	task automatic t_reset;
		rdchk(tts_pkg::ADDR_STATUS, 32'h0000000F, 32'(tts_pkg::ST_NORMAL));
		rdchk(tts_pkg::ADDR_DURATION, 32'h0000FFFF, 32'h00000096);
		chk(load_en, 1'b1);
		chk(meas.measure_en, 1'b1);
		chk({lamp_on, lamp_flash, beep, irq}, 32'h00000000);
	endtask : t_reset

	task automatic t_hold;
		apb(1'b1, tts_pkg::ADDR_IRQ_MASK, 32'h00000000);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_HOLD));
		chk(lamp_flash, 1'b1);
		chk(meas.measure_en, 1'b0);
		chk(meas.graph_en, 1'b1);
		chk(irq, 1'b0);
		apb(1'b1, tts_pkg::ADDR_IRQ_MASK, 32'h00000004);
		chk(irq, 1'b1);
		c = clr_cnt;
		panel.pulse(0);
		chk(32'(clr_cnt), 32'(c + 1));
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_HOLD));
		apb(1'b1, tts_pkg::ADDR_IRQ_STAT, 32'h00000004);
		chk(irq, 1'b0);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_NORMAL));
		chk(lamp_flash, 1'b0);
		chk(meas.measure_en, 1'b1);
		apb(1'b0, 8'hFC, 32'h00000000);
		chk({err, rd[30:0]}, 32'h80000000);
		// the unused type code must leave the untimed mode in place
		apb(1'b1, tts_pkg::ADDR_CTRL, 32'h00000003);
		rdchk(tts_pkg::ADDR_CTRL, 32'h00000003, 32'h00000000);
	endtask : t_hold

	task automatic t_manual;
		apb(1'b1, tts_pkg::ADDR_CTRL, 32'h00000005);
		rdchk(tts_pkg::ADDR_STATUS, 32'h0000000F, 32'h00000008);
		chk(load_en, 1'b0);
		c = clr_cnt;
		panel.pulse(0);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_RUNNING));
		chk({lamp_on, load_en}, 32'h00000003);
		chk(32'(clr_cnt), 32'(c + 1));
		repeat (3) panel.pulse(3);
		rdchk(tts_pkg::ADDR_ELAPSED, 32'hFFFFFFFF, 32'h00000003);
		panel.pulse(0);
		rdchk(tts_pkg::ADDR_ELAPSED, 32'hFFFFFFFF, 32'h00000000);
		panel.pulse(3);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_COMPLETE));
		rdchk(tts_pkg::ADDR_ELAPSED, 32'hFFFFFFFF, 32'h00000001);
		chk({lamp_flash, load_en, meas.measure_en}, 32'h00000004);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_NORMAL));
		rdchk(tts_pkg::ADDR_ELAPSED, 32'hFFFFFFFF, 32'h00000000);
	endtask : t_manual

	task automatic t_timed;
		apb(1'b1, tts_pkg::ADDR_DURATION, 32'h00000003);
		apb(1'b1, tts_pkg::ADDR_CTRL, 32'h00000002);
		rdchk(tts_pkg::ADDR_STATUS, 32'h0000000F, 32'(tts_pkg::ST_AWAIT));
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_AWAIT));
		panel.pulse(0);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_RUNNING));
		chk({lamp_on, load_en}, 32'h00000003);
		repeat (2) panel.pulse(3);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_RUNNING));
		panel.pulse(3);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_COMPLETE));
		chk({beep, lamp_flash}, 32'h00000003);
		rdchk(tts_pkg::ADDR_IRQ_STAT, 32'h00000001, 32'h00000001);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_AWAIT));
		rdchk(tts_pkg::ADDR_ELAPSED, 32'hFFFFFFFF, 32'h00000000);
		panel.pulse(0);
		panel.pulse(3);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_ABORTED));
		chk(lamp_flash, 1'b1);
		// a second reset silences the short beep, else the long one is invisible
		@(posedge clk);
		reset <= 1'b1;
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(negedge clk);
		chk({beep, lamp_flash, load_en}, 32'h00000001);
		apb(1'b1, tts_pkg::ADDR_DURATION, 32'h00000003);
		apb(1'b1, tts_pkg::ADDR_CTRL, 32'h00000006);
		rdchk(tts_pkg::ADDR_STATUS, 32'h0000000F, 32'h0000000A);
		panel.pulse(0);
		chk(load_en, 1'b1);
		panel.pulse(1);
		rdchk(tts_pkg::ADDR_STATUS, 32'h0000000F, 32'h0000000D);
		chk(beep, 1'b0);
		panel.pulse(1);
		panel.pulse(0);
		panel.pulse(2);
		rdchk(tts_pkg::ADDR_STATUS, 32'h00000007, 32'(tts_pkg::ST_ABORTED));
		chk(beep, 1'b1);
		rdchk(tts_pkg::ADDR_IRQ_STAT, 32'h00000002, 32'h00000002);
		apb(1'b1, tts_pkg::ADDR_DURATION, 32'h0000FFFF);
		rdchk(tts_pkg::ADDR_DURATION, 32'hFFFFFFFF, 32'h0000FFFF);
	endtask : t_timed

	task automatic wrap_up;
		$display("errors %0d, comparisons %0d", error_cnt, n_compared);
		if (error_cnt == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : wrap_up

	// main sequence; reset held for eight cycles
	initial begin
		clk     = 1'b0;
		reset   = 1'b1;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 8'h00;
		pwdata  = 32'h00000000;
		repeat (8) @(posedge clk);
		reset <= 1'b0;
		t_reset();
		t_hold();
		t_manual();
		t_timed();
		wrap_up();
	end

	// watchdog: the tests need a few hundred cycles
	initial begin
		repeat (20000) @(posedge clk);
		error_cnt++;
		wrap_up();
	end
endmodule : test_test_timing_sequencer

//--- dv/tts_panel.sv
// operator panel model: start, stop and overload keys plus the one-second tick
module tts_panel (
	// clock
	input  wire logic clk,
	// pins towards the sequencer
	output logic      start_key,
	output logic      stop_key,
	output logic      overload_in,
	output logic      sec_tick_in
);
	timeunit 1ns;
	timeprecision 1ps;

	// all pins quiet at time zero
	initial begin
		start_key   = 1'b0;
		stop_key    = 1'b0;
		overload_in = 1'b0;
		sec_tick_in = 1'b0;
	end

	// pin 0 start, 1 stop, 2 overload, 3 tick; high four cycles, then quiet
	// long enough for the synchroniser and both state edges to settle,
	// so one event per call keeps presses a safe distance apart
	task automatic pulse(input int pin);
		for (int i = 0; i < 14; i++) begin
			@(posedge clk);
			start_key   <= (pin == 0) && (i < 4);
			stop_key    <= (pin == 1) && (i < 4);
			overload_in <= (pin == 2) && (i < 4);
			sec_tick_in <= (pin == 3) && (i < 4);
		end
	endtask : pulse
endmodule : tts_panel

//--- logic/tts_beeper.sv
// beeper: short or long tone timer
module tts_beeper (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// requests
	input  wire logic short_req,
	input  wire logic long_req,
	// tone
	output logic      beep
);
	logic [31:0] cnt_reg;

	// long request wins if both arrive together
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			cnt_reg <= 32'h0000_0000;
		end else if (long_req) begin
			cnt_reg <= tts_pkg::LONG_BEEP_CYC;
		end else if (short_req) begin
			cnt_reg <= tts_pkg::SHORT_BEEP_CYC;
		end else if (cnt_reg != 32'h0000_0000) begin
			cnt_reg <= cnt_reg - 32'h0000_0001;
		end
	end

	assign beep = (cnt_reg != 32'h0000_0000);
endmodule : tts_beeper

//--- logic/tts_pkg.sv
// package for the test timing sequencer: register map, fields, enums
package tts_pkg;
	// register byte addresses
	localparam logic [7:0] ADDR_CTRL     = 8'h00;
	localparam logic [7:0] ADDR_DURATION = 8'h04;
	localparam logic [7:0] ADDR_STATUS   = 8'h08;
	localparam logic [7:0] ADDR_ELAPSED  = 8'h0C;
	localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;
	// ctrl fields
	localparam int CTRL_TYPE_LSB = 0;
	localparam int CTRL_LOAD_BIT = 2;
	// reset values
	localparam logic [15:0] DURATION_RESET = 16'h0096;
	// beep lengths in cycles at 200 MHz
	localparam int unsigned CLK_HZ        = 200000000;
	localparam int unsigned SHORT_BEEP_MS = 100;
	localparam int unsigned LONG_BEEP_MS  = 1000;
	localparam logic [31:0] SHORT_BEEP_CYC = 32'(CLK_HZ / 1000 * SHORT_BEEP_MS);
	localparam logic [31:0] LONG_BEEP_CYC  = 32'(CLK_HZ / 1000 * LONG_BEEP_MS);
	// interrupt bits
	localparam int IRQ_DONE  = 0;
	localparam int IRQ_ABORT = 1;
	localparam int IRQ_HOLD  = 2;
	localparam int IRQ_W     = 3;

	typedef enum logic [1:0] {
		TYPE_UNTIMED = 2'h0,
		TYPE_MANUAL  = 2'h1,
		TYPE_TIMED   = 2'h2
	} tts_test_type;

	typedef enum logic [2:0] {
		ST_NORMAL   = 3'h0,
		ST_HOLD     = 3'h1,
		ST_AWAIT    = 3'h2,
		ST_RUNNING  = 3'h3,
		ST_COMPLETE = 3'h4,
		ST_ABORTED  = 3'h5
	} tts_state_type;

	typedef struct packed {
		logic start;
		logic stop;
		logic overload;
	} tts_keys_type;

	typedef struct packed {
		logic measure_en;
		logic graph_en;
		logic minmax_clr;
	} tts_meas_type;
endpackage : tts_pkg

//--- logic/tts_sync.sv
// two-flop synchroniser with rising-edge pulse
module tts_sync (
	// clock and reset
	input  wire logic clk,
	input  wire logic reset,
	// async in, sync pulse out
	input  wire logic din,
	output logic      rise
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// first flop only feeds second; edge taken on later stages
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= din;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	assign rise = s2_reg & ~s3_reg;
endmodule : tts_sync

//--- logic/tts_top.sv
// test timing sequencer: modes, status, lamp, load gate, elapsed timer, apb
module tts_top (
	// clock and reset
	input  wire logic                 clk,
	input  wire logic                 reset,
	// apb slave
	input  wire logic                 psel,
	input  wire logic                 penable,
	input  wire logic                 pwrite,
	input  wire logic [7:0]           paddr,
	input  wire logic [31:0]          pwdata,
	output logic      [31:0]          prdata,
	output logic                      pready,
	output logic                      pslverr,
	// front panel and sensors (asynchronous)
	input  wire logic                 start_key,
	input  wire logic                 stop_key,
	input  wire logic                 overload_in,
	input  wire logic                 sec_tick_in,
	// outputs
	output logic                      lamp_on,
	output logic                      lamp_flash,
	output logic                      beep,
	output logic                      load_en,
	output tts_pkg::tts_meas_type     meas,
	output logic                      irq
);
	tts_pkg::tts_keys_type key;
	logic                  tick;
	tts_pkg::tts_test_type type_reg;
	logic                  load_during_reg;
	logic [15:0]           duration_reg;
	tts_pkg::tts_state_type state_reg;
	tts_pkg::tts_state_type state_next;
	logic [15:0]           elapsed_reg;
	logic [tts_pkg::IRQ_W-1:0] irq_stat_reg;
	logic [tts_pkg::IRQ_W-1:0] irq_mask_reg;
	logic [tts_pkg::IRQ_W-1:0] irq_event;
	logic                  wr_en;
	logic                  rd_en;
	logic                  type_wr;
	logic                  done_evt;
	logic                  abort_evt;
	logic                  clr_elapsed;
	logic [31:0]           prdata_next;

	// every pin passes two flops before use
	tts_sync u_start (.clk(clk), .reset(reset), .din(start_key),   .rise(key.start));
	tts_sync u_stop  (.clk(clk), .reset(reset), .din(stop_key),    .rise(key.stop));
	tts_sync u_ovl   (.clk(clk), .reset(reset), .din(overload_in), .rise(key.overload));
	tts_sync u_tick  (.clk(clk), .reset(reset), .din(sec_tick_in), .rise(tick));

	// apb: zero wait states, write and read on the access cycle
	assign wr_en   = psel & penable & pwrite;
	assign rd_en   = psel & penable & ~pwrite;
	assign pready  = 1'b1;
	assign type_wr = wr_en & (paddr == tts_pkg::ADDR_CTRL);

	function automatic logic mapped(input logic [7:0] a);
		mapped = (a == tts_pkg::ADDR_CTRL) || (a == tts_pkg::ADDR_DURATION) ||
			(a == tts_pkg::ADDR_STATUS) || (a == tts_pkg::ADDR_ELAPSED) ||
			(a == tts_pkg::ADDR_IRQ_STAT) || (a == tts_pkg::ADDR_IRQ_MASK);
	endfunction : mapped

	assign pslverr = psel & penable & ~mapped(paddr);

	// configuration registers
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			type_reg        <= tts_pkg::TYPE_UNTIMED;
			load_during_reg <= 1'b0;
			duration_reg    <= tts_pkg::DURATION_RESET;
			irq_mask_reg    <= '0;
		end else if (wr_en) begin
			case (paddr)
				tts_pkg::ADDR_CTRL: begin
					if (pwdata[tts_pkg::CTRL_TYPE_LSB +: 2] != 2'h3) begin
						type_reg <= tts_pkg::tts_test_type'(pwdata[tts_pkg::CTRL_TYPE_LSB +: 2]);
					end
					load_during_reg <= pwdata[tts_pkg::CTRL_LOAD_BIT];
				end
				// 16-bit field cannot hold more than 65535
				tts_pkg::ADDR_DURATION: duration_reg <= pwdata[15:0];
				tts_pkg::ADDR_IRQ_MASK: irq_mask_reg <= pwdata[tts_pkg::IRQ_W-1:0];
				default: ;
			endcase
		end
	end

	assign done_evt  = (state_reg == tts_pkg::ST_RUNNING) && (type_reg == tts_pkg::TYPE_TIMED)
		&& (elapsed_reg == duration_reg) && !key.start;
	assign abort_evt = (state_reg == tts_pkg::ST_RUNNING) && (type_reg == tts_pkg::TYPE_TIMED)
		&& !done_evt && (key.overload || key.stop);

	// sequencer next state; a mode write resets the sequence
	always_comb begin
		state_next = state_reg;
		if (type_wr) begin
			case (pwdata[tts_pkg::CTRL_TYPE_LSB +: 2])
				tts_pkg::TYPE_TIMED:  state_next = tts_pkg::ST_AWAIT;
				tts_pkg::TYPE_MANUAL: state_next = tts_pkg::ST_NORMAL;
				tts_pkg::TYPE_UNTIMED: state_next = tts_pkg::ST_NORMAL;
				default: state_next = state_reg;
			endcase
		end else begin
			case (state_reg)
				tts_pkg::ST_NORMAL: begin
					if (type_reg == tts_pkg::TYPE_UNTIMED && key.stop) begin
						state_next = tts_pkg::ST_HOLD;
					end else if (type_reg == tts_pkg::TYPE_MANUAL && key.start) begin
						state_next = tts_pkg::ST_RUNNING;
					end
				end
				tts_pkg::ST_HOLD: begin
					if (key.stop) begin
						state_next = tts_pkg::ST_NORMAL;
					end
				end
				tts_pkg::ST_AWAIT: begin
					if (key.start) begin
						state_next = tts_pkg::ST_RUNNING;
					end
				end
				tts_pkg::ST_RUNNING: begin
					if (done_evt) begin
						state_next = tts_pkg::ST_COMPLETE;
					end else if (abort_evt) begin
						state_next = tts_pkg::ST_ABORTED;
					end else if (type_reg == tts_pkg::TYPE_MANUAL && key.stop && !key.start) begin
						state_next = tts_pkg::ST_COMPLETE;
					end
				end
				tts_pkg::ST_COMPLETE, tts_pkg::ST_ABORTED: begin
					if (key.stop) begin
						state_next = (type_reg == tts_pkg::TYPE_TIMED) ?
							tts_pkg::ST_AWAIT : tts_pkg::ST_NORMAL;
					end
				end
				default: state_next = tts_pkg::ST_NORMAL;
			endcase
		end
	end

	// sequencer state
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			state_reg <= tts_pkg::ST_NORMAL;
		end else begin
			state_reg <= state_next;
		end
	end

	// elapsed clears on rearm, on a fresh start and on restart while running
	assign clr_elapsed = key.start && (state_reg == tts_pkg::ST_RUNNING ||
		state_next == tts_pkg::ST_RUNNING) ||
		(state_next == tts_pkg::ST_NORMAL || state_next == tts_pkg::ST_AWAIT);

	// elapsed seconds: a restart wins over a tick in the same cycle
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			elapsed_reg <= 16'h0000;
		end else if (clr_elapsed) begin
			elapsed_reg <= 16'h0000;
		end else if (state_reg == tts_pkg::ST_RUNNING && tick && !done_evt &&
			elapsed_reg != 16'hFFFF) begin
			elapsed_reg <= elapsed_reg + 16'h0001;
		end
	end

	// lamp, load, measurement gating from flops
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			lamp_on    <= 1'b0;
			lamp_flash <= 1'b0;
			load_en    <= 1'b1;
			meas       <= '{measure_en: 1'b1, graph_en: 1'b1, minmax_clr: 1'b0};
		end else begin
			lamp_on    <= (state_next == tts_pkg::ST_RUNNING);
			lamp_flash <= (state_next == tts_pkg::ST_HOLD) ||
				(state_next == tts_pkg::ST_COMPLETE) ||
				(state_next == tts_pkg::ST_ABORTED);
			// untimed always powers the load
			load_en    <= (type_reg == tts_pkg::TYPE_UNTIMED) || !load_during_reg ||
				(state_next == tts_pkg::ST_RUNNING);
			meas.measure_en <= !((state_next == tts_pkg::ST_HOLD) ||
				(state_next == tts_pkg::ST_COMPLETE) ||
				(state_next == tts_pkg::ST_ABORTED));
			meas.graph_en   <= 1'b1;
			meas.minmax_clr <= key.start;
		end
	end

	// beeps: short on timed completion, long on overload abort
	tts_beeper u_beep (
		.clk      (clk),
		.reset    (reset),
		.short_req(done_evt),
		.long_req (abort_evt & key.overload),
		.beep     (beep)
	);

	// sticky interrupt status, write one to clear, set wins
	assign irq_event = {key.stop & (state_reg == tts_pkg::ST_NORMAL) &
		(type_reg == tts_pkg::TYPE_UNTIMED), abort_evt, done_evt};
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			irq_stat_reg <= '0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((wr_en && paddr == tts_pkg::ADDR_IRQ_STAT) ?
				pwdata[tts_pkg::IRQ_W-1:0] : '0)) | irq_event;
		end
	end
	assign irq = |(irq_stat_reg & irq_mask_reg);

	// read mux
	always_comb begin
		prdata_next = 32'h0000_0000;
		case (paddr)
			tts_pkg::ADDR_CTRL: begin
				prdata_next[tts_pkg::CTRL_TYPE_LSB +: 2] = type_reg;
				prdata_next[tts_pkg::CTRL_LOAD_BIT]      = load_during_reg;
			end
			tts_pkg::ADDR_DURATION: prdata_next[15:0] = duration_reg;
			// status: state code and load-off flag
			tts_pkg::ADDR_STATUS:   prdata_next[3:0] = {~load_en, state_reg};
			tts_pkg::ADDR_ELAPSED:  prdata_next[15:0] = elapsed_reg;
			tts_pkg::ADDR_IRQ_STAT: prdata_next[tts_pkg::IRQ_W-1:0] = irq_stat_reg;
			tts_pkg::ADDR_IRQ_MASK: prdata_next[tts_pkg::IRQ_W-1:0] = irq_mask_reg;
			default: prdata_next = 32'h0000_0000;
		endcase
	end
	// read data registered on the setup cycle so it is stable in access
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			prdata <= 32'h0000_0000;
		end else if (psel && !penable) begin
			prdata <= prdata_next;
		end
	end

	// assertions
	start_runs_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == tts_pkg::ST_AWAIT && key.start && !type_wr) |=>
		(state_reg == tts_pkg::ST_RUNNING) && lamp_on)
		else $error("start did not run test");
	flash_holds_a: assert property (@(posedge clk) disable iff (reset)
		lamp_flash |-> !meas.measure_en)
		else $error("measurement live while flashing");
	graph_live_a: assert property (@(posedge clk) disable iff (reset)
		meas.graph_en) else $error("graph frozen");
	minmax_clear_a: assert property (@(posedge clk) disable iff (reset)
		key.start |=> meas.minmax_clr) else $error("min max not cleared");
	done_beep_a: assert property (@(posedge clk) disable iff (reset)
		done_evt |=> (state_reg == tts_pkg::ST_COMPLETE) && beep && lamp_flash)
		else $error("completion wrong");
	restart_zero_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == tts_pkg::ST_RUNNING && key.start && !type_wr) |=> elapsed_reg == 16'h0000)
		else $error("restart kept time");
	tick_count_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == tts_pkg::ST_RUNNING && tick && !clr_elapsed && !done_evt &&
		elapsed_reg != 16'hFFFF) |=> elapsed_reg == $past(elapsed_reg) + 16'h0001)
		else $error("tick not counted");
	abort_long_a: assert property (@(posedge clk) disable iff (reset)
		(abort_evt && key.overload) |=> state_reg == tts_pkg::ST_ABORTED && beep)
		else $error("overload abort wrong");
	load_gate_a: assert property (@(posedge clk) disable iff (reset)
		(load_during_reg && type_reg != tts_pkg::TYPE_UNTIMED &&
		state_reg == tts_pkg::ST_AWAIT) |-> ##1 (!load_en || state_reg == tts_pkg::ST_RUNNING))
		else $error("load on outside test");
	manual_keep_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == tts_pkg::ST_COMPLETE && !key.stop && !type_wr) |=>
		$stable(elapsed_reg)) else $error("elapsed lost after completion");
	rearm_a: assert property (@(posedge clk) disable iff (reset)
		(state_reg == tts_pkg::ST_COMPLETE && type_reg == tts_pkg::TYPE_MANUAL &&
		key.stop && !type_wr) |=> state_reg == tts_pkg::ST_NORMAL && elapsed_reg == 16'h0000)
		else $error("rearm failed");
endmodule : tts_top
